// File: rtl/guard_pkg.sv
// shared constants and carrier types for the ram and peripheral access guard
package guard_pkg;
	// ram region geometry
	localparam int RAM_REGIONS = 32;
	localparam int REGION_KIB = 8;
	localparam int REGION_BYTES = REGION_KIB * 1024;
	localparam int REGION_SHIFT = $clog2(REGION_BYTES);
	localparam int RIDX_W = $clog2(RAM_REGIONS);
	// callable entry area descriptors, extent counted in units of 2**CA_UNIT_SHIFT bytes
	localparam int CA_DESCS = 2;
	localparam int CA_EXT_W = 5;
	localparam int CA_UNIT_SHIFT = 8;
	// peripheral alias nibbles, address bits 31:28
	localparam logic [3:0] ALIAS_NSEC = 4'h4;
	localparam logic [3:0] ALIAS_SEC = 4'h5;
	// register map, byte offsets
	localparam int REG_AW = 12;
	localparam int REG_BLK_LSB = 8;
	localparam int REG_IDX_LSB = 2;
	localparam logic [11:0] EVT_STATUS_OFS = 12'h000;
	localparam logic [11:0] CA_BASE_OFS = 12'h010;
	localparam logic [11:0] RAM_RIGHTS_OFS = 12'h100;
	localparam logic [11:0] PERIPH_SLOT_OFS = 12'h200;
	// ram region register fields
	localparam int RIGHT_LOCK = 8;
	// peripheral slot fields
	localparam int F_CLASS = 0;
	localparam int F_INDEP = 2;
	localparam int F_CFG = 3;
	localparam int F_PSEC = 4;
	localparam int F_DSEC = 5;
	// event status bits
	localparam int EVT_RAM = 0;
	localparam int EVT_PERIPH = 1;

	typedef struct packed {
		logic secure;
		logic exec;
		logic write;
		logic read;
	} ram_region_permission_t;

	localparam ram_region_permission_t RAM_RIGHTS_RST = 4'hf;

	typedef enum logic [1:0] {MAP_SEC, MAP_NSEC, MAP_CFG, MAP_SPLIT} attr_mapping_class_t;
	typedef enum logic [1:0] {MST_CPU, MST_DMA, MST_OTHER} master_t;

	typedef struct packed {
		logic [31:0] addr;
		logic write;
		logic fetch;
		logic secure;
		master_t master;
		logic err_capable;
		logic secure_reg;
	} xfer_req_t;

	typedef struct packed {
		logic bus_err;
		logic security_fault_exc;
		logic bus_fault_exc;
	} fault_t;
endpackage : guard_pkg

// File: rtl/region_rights_slot.sv
// one ram region permission set with its lock
`timescale 1ns/1ps
`default_nettype none
module region_rights_slot #(
	parameter guard_pkg::ram_region_permission_t RST_RIGHTS = guard_pkg::RAM_RIGHTS_RST
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// software write
	input wire logic wr_i,
	input wire guard_pkg::ram_region_permission_t rights_i,
	input wire logic lock_i,
	// held setting
	output guard_pkg::ram_region_permission_t rights_o,
	output logic lock_o
);
	typedef struct packed {
		guard_pkg::ram_region_permission_t rights;
		logic lock;
	} slot_t;

	slot_t st_r;
	slot_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		// lock only clears at reset, so a locked set cannot be reopened
		if (wr_i && !st_r.lock) begin // RL5
			st_nxt.rights = rights_i;
			st_nxt.lock = lock_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st_r.rights <= RST_RIGHTS;
			st_r.lock <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rights_o = st_r.rights;
	assign lock_o = st_r.lock;

	chk_lock_freeze: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL5
		lock_o |=> lock_o && $stable(rights_o))
		else $error("locked region rights changed");
endmodule : region_rights_slot
`default_nettype wire

// File: rtl/ram_periph_access_guard.sv
// ram and peripheral access guard with avalon-mm register slave
`timescale 1ns/1ps
`default_nettype none
// Operation
// RL1: ram split into 32 regions of 8 KiB
// RL2: read, write, execute, secure per region
// RL3: fetch gated by execute, reads by read
// RL4: secure region admits only secure transfers; the code also admits non-secure fetches into its callable area
// RL5: lock bit freezes region settings
// RL6: callable area grows down from region top
// RL7: callable area needs nonzero extent, secure region
// RL8: same region twice takes larger extent
// RL9: blocked ram read returns zero
// RL10: bus error to masters that support it
// RL11: cpu security fault, else bus fault plus event
// RL12: other masters get drop plus ram event
// RL13: security fault wins over bus fault
// RL14: slot reports class, takes flag if configurable
// RL15: reset makes configurable peripherals and dma secure
// RL16: secure transfers reach all peripherals
// RL17: split peripheral secure takes secure only
// RL18: nonsecure alias 0x4, secure alias 0x5
// RL19: split nonsecure: both aliases, secure registers hidden
// RL20: nonsecure into 0x5 alias dropped, security fault
// RL21: independent dma flag only when class allows
// RL22: peripheral violation blocks, errors, faults, event; the code raises a fault only for cpu non-secure transfers into the 0x5 alias
// RL23: dropped writes change nothing, reads leak nothing
// RL24: error events collected into status flags
// RL25: region index from offset, same cycle check
// RL26: one pulse per blocked transfer, sticky flag; the code raises no pulse for quiet drops of hidden split registers
module ram_periph_access_guard #(
	parameter int NUM_PERIPH = 16,
	parameter int PERIPH_ID_LSB = 12,
	parameter logic [31:0] RAM_BASE = 32'h2000_0000,
	parameter logic [2*NUM_PERIPH-1:0] MAP_TBL = {NUM_PERIPH{2'h2}},
	parameter logic [NUM_PERIPH-1:0] INDEP_DMA_TBL = {NUM_PERIPH{1'b1}},
	parameter logic [NUM_PERIPH-1:0] HAS_DMA_TBL = {NUM_PERIPH{1'b1}}
) (
	// clock and reset
	input wire logic SYS_CLK_I,
	input wire logic RST_N_I,
	// register slave
	input wire logic [11:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	output logic [31:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	// monitored transfer, address phase
	input wire logic XFER_VALID_I,
	input wire guard_pkg::xfer_req_t XFER_I,
	output logic XFER_ALLOW_O,
	output logic XFER_CALLABLE_O,
	// monitored transfer, data phase
	input wire logic [31:0] SLAVE_RDATA_I,
	output logic [31:0] XFER_RDATA_O,
	output guard_pkg::fault_t FAULT_O,
	// events and dma attributes
	output logic RAM_ACCESS_ERROR_EVENT_O,
	output logic PERIPH_ACCESS_ERROR_EVENT_O,
	output logic [NUM_PERIPH-1:0] DMA_TRANSFER_SECURE_O
);
	localparam int PID_W = (NUM_PERIPH > 1) ? $clog2(NUM_PERIPH) : 1;
	localparam int WW = guard_pkg::REG_BLK_LSB - guard_pkg::REG_IDX_LSB;
	localparam logic [31:0] RAM_SPAN = 32'(guard_pkg::RAM_REGIONS * guard_pkg::REGION_BYTES);
	localparam logic [WW-1:0] CA_W0 =
		guard_pkg::CA_BASE_OFS[guard_pkg::REG_BLK_LSB-1:guard_pkg::REG_IDX_LSB];
	localparam logic [WW-1:0] CA_WN = WW'(2 * guard_pkg::CA_DESCS);

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [guard_pkg::CA_DESCS-1:0][guard_pkg::RIDX_W-1:0] ca_region;
		logic [guard_pkg::CA_DESCS-1:0][guard_pkg::CA_EXT_W-1:0] ca_extent;
		logic [NUM_PERIPH-1:0] psec;
		logic [NUM_PERIPH-1:0] dsec;
		logic [1:0] status;
		guard_pkg::fault_t fault;
		logic ram_evt;
		logic per_evt;
		logic dph;
		logic dblk;
		logic [31:0] xdata;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	guard_pkg::ram_region_permission_t [guard_pkg::RAM_REGIONS-1:0] rights;
	logic [guard_pkg::RAM_REGIONS-1:0] locks;
	logic [NUM_PERIPH-1:0] eff_psec;

	// register bus decode
	logic req;
	logic wr_go;
	logic [3:0] blk;
	logic [WW-1:0] w;
	logic [WW-1:0] ca_w;
	logic ram_sel;
	logic per_sel;
	logic ca_sel;
	logic [guard_pkg::RIDX_W-1:0] rsel;
	logic [PID_W-1:0] psel;
	guard_pkg::attr_mapping_class_t wcls;

	// transfer decode
	logic [31:0] ram_ofs;
	logic ram_hit;
	logic per_hit;
	logic asec;
	logic [guard_pkg::RIDX_W-1:0] ridx;
	guard_pkg::ram_region_permission_t rp;
	logic [guard_pkg::CA_EXT_W-1:0] ext;
	logic [guard_pkg::REGION_SHIFT:0] ca_sum;
	logic callable;
	logic r_sec;
	logic r_acc;
	logic [PID_W-1:0] pid;
	guard_pkg::attr_mapping_class_t cls;
	logic mapped;
	logic quiet;
	logic sec_viol;
	logic acc_viol;
	logic viol;
	logic blocked;
	logic cpu;

	assign req = AVS_READ_I || AVS_WRITE_I;
	assign AVS_WAITREQUEST_O = req && !st_r.ack;
	assign wr_go = AVS_WRITE_I && st_r.ack;
	assign blk = AVS_ADDRESS_I[guard_pkg::REG_AW-1:guard_pkg::REG_BLK_LSB];
	assign w = AVS_ADDRESS_I[guard_pkg::REG_BLK_LSB-1:guard_pkg::REG_IDX_LSB];
	assign ca_w = w - CA_W0;
	assign ram_sel = blk == guard_pkg::RAM_RIGHTS_OFS[guard_pkg::REG_AW-1:guard_pkg::REG_BLK_LSB]
		&& 32'(w) < guard_pkg::RAM_REGIONS;
	assign per_sel = blk == guard_pkg::PERIPH_SLOT_OFS[guard_pkg::REG_AW-1:guard_pkg::REG_BLK_LSB]
		&& 32'(w) < NUM_PERIPH;
	assign ca_sel = blk == guard_pkg::CA_BASE_OFS[guard_pkg::REG_AW-1:guard_pkg::REG_BLK_LSB]
		&& w >= CA_W0 && ca_w < CA_WN;
	assign rsel = w[guard_pkg::RIDX_W-1:0];
	assign psel = PID_W'(w);
	assign wcls = guard_pkg::attr_mapping_class_t'(MAP_TBL[2*psel +: 2]);

	genvar g;
	generate
		for (g = 0; g < guard_pkg::RAM_REGIONS; g++) begin : g_region
			region_rights_slot u_slot (
				.clk_i(SYS_CLK_I),
				.rst_n_i(RST_N_I),
				.wr_i(wr_go && ram_sel && rsel == g),
				.rights_i(AVS_WRITEDATA_I[3:0]),
				.lock_i(AVS_WRITEDATA_I[guard_pkg::RIGHT_LOCK]),
				.rights_o(rights[g]),
				.lock_o(locks[g])
			);
		end
		for (g = 0; g < NUM_PERIPH; g++) begin : g_periph
			localparam guard_pkg::attr_mapping_class_t C =
				guard_pkg::attr_mapping_class_t'(MAP_TBL[2*g +: 2]);
			// hardwired classes ignore the stored flag
			assign eff_psec[g] = (C == guard_pkg::MAP_SEC) ? 1'b1 :
				(C == guard_pkg::MAP_NSEC) ? 1'b0 : st_r.psec[g]; // RL14
			assign DMA_TRANSFER_SECURE_O[g] = HAS_DMA_TBL[g] &&
				((INDEP_DMA_TBL[g] && eff_psec[g]) ? st_r.dsec[g] : eff_psec[g]); // RL21
		end
	endgenerate

	// access decision, combinational in the address phase
	always_comb begin
		cpu = XFER_I.master == guard_pkg::MST_CPU;
		ram_ofs = XFER_I.addr - RAM_BASE;
		ram_hit = XFER_I.addr >= RAM_BASE && ram_ofs < RAM_SPAN; // RL1
		ridx = ram_ofs[guard_pkg::REGION_SHIFT +: guard_pkg::RIDX_W]; // RL25
		rp = rights[ridx];
		ext = '0;
		for (int d = 0; d < guard_pkg::CA_DESCS; d++) begin
			// a non-secure region never gets a callable area
			if (st_r.ca_region[d] == ridx && rp.secure && st_r.ca_extent[d] > ext) begin // RL7 RL8
				ext = st_r.ca_extent[d];
			end
		end
		ca_sum = {1'b0, ram_ofs[guard_pkg::REGION_SHIFT-1:0]}
			+ ((guard_pkg::REGION_SHIFT + 1)'(ext) << guard_pkg::CA_UNIT_SHIFT);
		callable = ram_hit && ext != '0 && ca_sum[guard_pkg::REGION_SHIFT]; // RL6
		// callable area lets non-secure code fetch secure entry points
		r_sec = rp.secure && !XFER_I.secure && !(callable && XFER_I.fetch); // RL4
		r_acc = XFER_I.fetch ? !rp.exec : (XFER_I.write ? !rp.write : !rp.read); // RL2 RL3
		asec = XFER_I.addr[31:28] == guard_pkg::ALIAS_SEC;
		per_hit = asec || XFER_I.addr[31:28] == guard_pkg::ALIAS_NSEC;
		pid = XFER_I.addr[PERIPH_ID_LSB +: PID_W];
		cls = guard_pkg::attr_mapping_class_t'(MAP_TBL[2*pid +: 2]);
		mapped = 32'(pid) < NUM_PERIPH &&
			(asec ? (eff_psec[pid] || cls == guard_pkg::MAP_SPLIT) : !eff_psec[pid]); // RL18 RL19
		// secure registers behind the 0x4 alias drop silently, no error
		quiet = per_hit && !asec && cls == guard_pkg::MAP_SPLIT && XFER_I.secure_reg; // RL19
		if (ram_hit) begin
			sec_viol = r_sec;
			acc_viol = r_acc;
		end else begin
			sec_viol = per_hit && asec && !XFER_I.secure; // RL16 RL17 RL20
			acc_viol = per_hit && !mapped;
		end
		viol = XFER_VALID_I && (sec_viol || acc_viol);
		blocked = viol || (XFER_VALID_I && quiet);
	end

	assign XFER_ALLOW_O = XFER_VALID_I && !blocked; // RL9 RL23
	assign XFER_CALLABLE_O = callable;

	always_comb begin
		st_nxt = st_r;
		// register slave: one wait state, read data stands at the ack edge
		st_nxt.ack = req && !st_r.ack;
		st_nxt.rdata = '0;
		if (AVS_READ_I && !st_r.ack) begin
			if (AVS_ADDRESS_I == guard_pkg::EVT_STATUS_OFS) begin
				st_nxt.rdata[1:0] = st_r.status;
			end else if (ca_sel && ca_w[0]) begin
				st_nxt.rdata[guard_pkg::CA_EXT_W-1:0] = st_r.ca_extent[ca_w[WW-1:1]];
			end else if (ca_sel) begin
				st_nxt.rdata[guard_pkg::RIDX_W-1:0] = st_r.ca_region[ca_w[WW-1:1]];
			end else if (ram_sel) begin
				st_nxt.rdata[3:0] = rights[rsel];
				st_nxt.rdata[guard_pkg::RIGHT_LOCK] = locks[rsel];
			end else if (per_sel) begin
				st_nxt.rdata[guard_pkg::F_CLASS +: 2] = wcls;
				st_nxt.rdata[guard_pkg::F_INDEP] = INDEP_DMA_TBL[psel];
				st_nxt.rdata[guard_pkg::F_CFG] = wcls == guard_pkg::MAP_CFG
					|| wcls == guard_pkg::MAP_SPLIT; // RL14
				st_nxt.rdata[guard_pkg::F_PSEC] = eff_psec[psel];
				st_nxt.rdata[guard_pkg::F_DSEC] = DMA_TRANSFER_SECURE_O[psel];
			end
		end
		if (wr_go && ca_sel && ca_w[0]) begin
			st_nxt.ca_extent[ca_w[WW-1:1]] = AVS_WRITEDATA_I[guard_pkg::CA_EXT_W-1:0];
		end
		if (wr_go && ca_sel && !ca_w[0]) begin
			st_nxt.ca_region[ca_w[WW-1:1]] = AVS_WRITEDATA_I[guard_pkg::RIDX_W-1:0];
		end
		if (wr_go && per_sel && (wcls == guard_pkg::MAP_CFG || wcls == guard_pkg::MAP_SPLIT)) begin
			st_nxt.psec[psel] = AVS_WRITEDATA_I[guard_pkg::F_PSEC]; // RL14
			if (INDEP_DMA_TBL[psel]) begin
				st_nxt.dsec[psel] = AVS_WRITEDATA_I[guard_pkg::F_DSEC]; // RL21
			end
		end
		// sticky flags: a pulse in the clearing cycle keeps its flag set
		for (int e = 0; e < 2; e++) begin
			if (wr_go && AVS_ADDRESS_I == guard_pkg::EVT_STATUS_OFS && AVS_WRITEDATA_I[e]) begin
				st_nxt.status[e] = 1'b0;
			end
		end
		if (st_r.ram_evt) begin
			st_nxt.status[guard_pkg::EVT_RAM] = 1'b1; // RL24 RL26
		end
		if (st_r.per_evt) begin
			st_nxt.status[guard_pkg::EVT_PERIPH] = 1'b1; // RL24 RL26
		end
		// reporting, one registered pulse per violating transfer, none for quiet drops
		st_nxt.fault.security_fault_exc = viol && cpu && sec_viol; // RL11 RL13 RL20 RL22
		st_nxt.fault.bus_fault_exc = viol && cpu && ram_hit && !sec_viol; // RL11 RL13
		st_nxt.fault.bus_err = viol && XFER_I.err_capable; // RL10 RL22
		st_nxt.ram_evt = viol && ram_hit && !(cpu && sec_viol); // RL11 RL12 RL26
		st_nxt.per_evt = viol && !ram_hit; // RL22 RL26
		// data phase follows the address phase by one cycle
		st_nxt.dph = XFER_VALID_I && !XFER_I.write;
		st_nxt.dblk = blocked;
		st_nxt.xdata = (st_r.dph && !st_r.dblk) ? SLAVE_RDATA_I : '0; // RL9 RL23
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			st_r <= '0;
			st_r.psec <= '1; // RL15
			st_r.dsec <= '1; // RL15
		end else begin
			st_r <= st_nxt;
		end
	end

	assign AVS_READDATA_O = st_r.rdata;
	assign XFER_RDATA_O = st_r.xdata;
	assign FAULT_O = st_r.fault;
	assign RAM_ACCESS_ERROR_EVENT_O = st_r.ram_evt;
	assign PERIPH_ACCESS_ERROR_EVENT_O = st_r.per_evt;

	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!RST_N_I);

	sequence s_blocked_read;
		XFER_VALID_I && !XFER_ALLOW_O && !XFER_I.write;
	endsequence

	sequence s_cpu_ram_viol;
		XFER_VALID_I && ram_hit && cpu && (sec_viol || acc_viol);
	endsequence

	chk_read_zeroed: assert property (s_blocked_read |-> ##2 XFER_RDATA_O == '0) // RL9
		else $error("blocked read returned data");

	chk_sec_first: assert property (s_cpu_ram_viol ##0 sec_viol |=> // RL13
		FAULT_O.security_fault_exc && !FAULT_O.bus_fault_exc && !RAM_ACCESS_ERROR_EVENT_O)
		else $error("security fault did not take precedence");

	chk_ram_bus_fault_exc: assert property (s_cpu_ram_viol ##0 !sec_viol |=> // RL11
		FAULT_O.bus_fault_exc && RAM_ACCESS_ERROR_EVENT_O)
		else $error("cpu access violation missed bus fault or event");

	chk_other_master: assert property (XFER_VALID_I && ram_hit && !cpu && sec_viol |=> // RL12
		RAM_ACCESS_ERROR_EVENT_O && !FAULT_O.security_fault_exc && !FAULT_O.bus_fault_exc)
		else $error("non-cpu violation handled wrongly");

	chk_fetch_exec: assert property (XFER_VALID_I && ram_hit && XFER_I.fetch && !rp.exec // RL3
		|-> !XFER_ALLOW_O)
		else $error("fetch allowed without execute right");

	chk_sec_alias: assert property (XFER_VALID_I && !ram_hit && asec && !XFER_I.secure // RL20
		|-> !XFER_ALLOW_O ##1 PERIPH_ACCESS_ERROR_EVENT_O ##1 st_r.status[guard_pkg::EVT_PERIPH])
		else $error("non-secure access into secure alias not blocked");

	chk_flag_latch: assert property (RAM_ACCESS_ERROR_EVENT_O |=> // RL26
		st_r.status[guard_pkg::EVT_RAM])
		else $error("ram error flag not latched");

	chk_bus_err: assert property (viol && XFER_I.err_capable |=> FAULT_O.bus_err) // RL10
		else $error("bus error not returned");

	chk_dma_follow: assert property (HAS_DMA_TBL[0] && !(INDEP_DMA_TBL[0] && eff_psec[0]) // RL21
		|-> DMA_TRANSFER_SECURE_O[0] == eff_psec[0])
		else $error("dma attribute does not follow peripheral");

	chk_bus_wait: assert property (req && !st_r.ack |-> AVS_WAITREQUEST_O ##1
		(!req || !AVS_WAITREQUEST_O))
		else $error("register access not answered after one wait state");

	chk_quiet_drop: assert property (XFER_VALID_I && quiet && !(sec_viol || acc_viol) // RL19
		|-> !XFER_ALLOW_O ##1 FAULT_O == '0 && !PERIPH_ACCESS_ERROR_EVENT_O)
		else $error("hidden split register access raised an error");

	chk_callable_sec: assert property (XFER_CALLABLE_O |-> ram_hit && rp.secure) // RL7
		else $error("callable area outside a secure region");

	chk_callable_fetch: assert property (XFER_VALID_I && XFER_CALLABLE_O && XFER_I.fetch // RL6
		&& rp.exec |-> XFER_ALLOW_O)
		else $error("fetch into callable area blocked");
endmodule : ram_periph_access_guard
`default_nettype wire

// File: verification/target_model.sv
// target slave model answering monitored reads one cycle after the address phase
`timescale 1ns/1ps
`default_nettype none
module target_model (
	// clock
	input wire logic clk_i,
	// monitored transfer
	input wire logic valid_i,
	input wire guard_pkg::xfer_req_t req_i,
	input wire logic allow_i,
	// read data
	output logic [31:0] rdata_o
);
	initial rdata_o = 32'h0;
	// when not answering, the bus toggles so a stale word never passes for read data
	always @(posedge clk_i) begin
		if (valid_i && allow_i && !req_i.write) begin
			rdata_o <= {req_i.addr[15:0] ^ 16'h3c5a, req_i.addr[31:16]};
		end else begin
			rdata_o <= ~rdata_o;
		end
	end
endmodule : target_model
`default_nettype wire

// File: verification/testbench.sv
// self-checking bench for the ram and peripheral access guard
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam logic [31:0] RB = 32'h2000_0000;
	localparam guard_pkg::master_t CPU = guard_pkg::MST_CPU;
	localparam guard_pkg::master_t DMA = guard_pkg::MST_DMA;
	logic clk, rst_n, rd, wr, xv, wreq, allow, callable, ram_ev, per_ev;
	logic [11:0] adr;
	logic [31:0] wdat, rdat, srd, xrd;
	logic [15:0] dma;
	guard_pkg::xfer_req_t xreq;
	guard_pkg::fault_t flt;
	int n_mismatch = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [31:0] seed = 32'hc0ed2191;

	// peripheral 0 always secure with dma tied to it, peripheral 3 split, the rest configurable
	ram_periph_access_guard #(.MAP_TBL(32'haaaa_aae8), .INDEP_DMA_TBL(16'hfffe)) u_dut (
		.SYS_CLK_I(clk), .RST_N_I(rst_n),
		.AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat),
		.AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq),
		.XFER_VALID_I(xv), .XFER_I(xreq), .XFER_ALLOW_O(allow), .XFER_CALLABLE_O(callable),
		.SLAVE_RDATA_I(srd), .XFER_RDATA_O(xrd), .FAULT_O(flt),
		.RAM_ACCESS_ERROR_EVENT_O(ram_ev), .PERIPH_ACCESS_ERROR_EVENT_O(per_ev),
		.DMA_TRANSFER_SECURE_O(dma)
	);

	target_model u_tgt (.clk_i(clk), .valid_i(xv), .req_i(xreq), .allow_i(allow), .rdata_o(srd));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : final_report

	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			final_report();
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	function automatic logic [31:0] pat(input logic [31:0] a);
		return {a[15:0] ^ 16'h3c5a, a[31:16]};
	endfunction : pat

	// f = write, fetch, secure, secure register, error capable
	function automatic guard_pkg::xfer_req_t mk(input logic [31:0] a, input logic [4:0] f,
		input guard_pkg::master_t m);
		guard_pkg::xfer_req_t r;
		r.addr = a;
		{r.write, r.fetch, r.secure, r.secure_reg, r.err_capable} = f;
		r.master = m;
		return r;
	endfunction : mk

	// expected {callable, allow, bus_err, sec fault, bus fault, ram event, periph event}
	function automatic logic [6:0] ram_exp(input guard_pkg::xfer_req_t r, input logic [3:0] p);
		logic sv, av;
		sv = p[3] && !r.secure;
		av = r.fetch ? !p[2] : (r.write ? !p[1] : !p[0]);
		if (r.master == guard_pkg::MST_CPU) begin
			return {1'b0, !sv && !av, r.err_capable && (sv || av), sv, !sv && av, !sv && av, 1'b0};
		end
		return {1'b0, !sv && !av, r.err_capable && (sv || av), 2'b00, sv || av, 1'b0};
	endfunction : ram_exp

	// holds the request until waitrequest is seen low at a rising edge
	task automatic avs(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
		end while (wreq !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : avs

	task automatic wreg(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		avs(1'b1, a, d, q);
	endtask : wreg

	task automatic rreg(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		avs(1'b0, a, 32'h0, q);
		chk($sformatf("register %h", a), q, e);
	endtask : rreg

	task automatic xf(input guard_pkg::xfer_req_t r, input logic [6:0] e);
		@(posedge clk);
		xv <= 1'b1;
		xreq <= r;
		#1;
		chk($sformatf("decision %h", r.addr), {callable, allow}, e[6:5]);
		@(posedge clk);
		xv <= 1'b0;
		#1;
		chk($sformatf("faults %h", r.addr), {flt, ram_ev, per_ev}, e[4:0]);
		@(posedge clk);
		#1;
		if (!r.write) begin
			chk($sformatf("read data %h", r.addr), xrd, e[5] ? pat(r.addr) : 32'h0);
		end
		chk("event pulse end", {ram_ev, per_ev}, 2'b00);
	endtask : xf

	initial begin
		logic [31:0] v, a;
		int rg;
		guard_pkg::xfer_req_t r;
		rst_n = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		adr = 12'h0;
		wdat = 32'h0;
		xv = 1'b0;
		xreq = '0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rreg(12'h100, 32'h0000_000f);
		rreg(12'h200, 32'h0000_0030);
		rreg(12'h204, 32'h0000_003e);
		chk("dma secure", {16'h0, dma}, 32'h0000_ffff);
		rreg(12'hffc, 32'h0);
		// random rights and attributes over regions 0..30, region 31 kept for the lock case
		for (int i = 0; i < 40; i++) begin
			rg = xs() % 31;
			v = xs();
			wreg(12'h100 + 12'(rg * 4), {28'h0, v[3:0]});
			a = RB + 32'(rg) * 32'h2000 + (xs() & 32'h1ffc);
			r = mk(a, {v[4], v[5] & !v[4], v[6], 1'b0, v[7]}, guard_pkg::master_t'(v[9:8] % 3));
			xf(r, ram_exp(r, v[3:0]));
		end
		wreg(12'h17c, 32'h0000_010b);
		wreg(12'h17c, 32'h0);
		rreg(12'h17c, 32'h0000_010b);
		xf(mk(RB + 32'h3_fffc, 5'b00001, DMA), 7'b0010010);
		wreg(12'h128, 32'h0000_000f);
		wreg(12'h010, 32'd10);
		wreg(12'h014, 32'd2);
		wreg(12'h018, 32'd10);
		wreg(12'h01c, 32'd5);
		xf(mk(32'h2001_5b00, 5'b01001, CPU), 7'b1100000);
		xf(mk(32'h2001_5afc, 5'b01001, CPU), 7'b0011000);
		wreg(12'h014, 32'h0);
		wreg(12'h01c, 32'h0);
		xf(mk(32'h2001_5ffc, 5'b01001, CPU), 7'b0011000);
		wreg(12'h12c, 32'h0000_0007);
		wreg(12'h010, 32'd11);
		wreg(12'h014, 32'd3);
		xf(mk(32'h2001_7ffc, 5'b01001, CPU), 7'b0100000);
		xf(mk(32'h4000_3000, 5'b00001, CPU), 7'b0010001);
		wreg(12'h200, 32'h0000_0020);
		rreg(12'h200, 32'h0000_0030);
		wreg(12'h204, 32'h0);
		rreg(12'h204, 32'h0000_000e);
		wreg(12'h208, 32'h0000_0010);
		rreg(12'h208, 32'h0000_001e);
		wreg(12'h20c, 32'h0);
		// the flag write lands at the ack edge, so look one edge later
		@(posedge clk);
		chk("dma secure", {16'h0, dma}, 32'h0000_fff1);
		xf(mk(32'h4000_1000, 5'b00001, CPU), 7'b0100000);
		xf(mk(32'h5000_1000, 5'b00001, CPU), 7'b0011001);
		xf(mk(32'h5000_1004, 5'b00101, CPU), 7'b0010001);
		xf(mk(32'h5000_1008, 5'b00001, DMA), 7'b0010001);
		xf(mk(32'h5000_2000, 5'b00101, CPU), 7'b0100000);
		xf(mk(32'h4000_1004, 5'b00101, CPU), 7'b0100000);
		xf(mk(32'h4000_2000, 5'b00101, CPU), 7'b0010001);
		xf(mk(32'h4000_3000, 5'b00011, CPU), 7'b0000000);
		xf(mk(32'h4000_3004, 5'b10001, CPU), 7'b0100000);
		xf(mk(32'h5000_3000, 5'b00111, CPU), 7'b0100000);
		xf(mk(32'h5000_0000, 5'b00101, CPU), 7'b0100000);
		rreg(12'h000, 32'h0000_0003);
		wreg(12'h000, 32'h0000_0001);
		rreg(12'h000, 32'h0000_0002);
		final_report();
	end
endmodule : testbench
`default_nettype wire
